// ===== logic/core_pkg.sv
package core_pkg;

  // Datapath widths and storage depths
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int RAM_AW = 9;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_AW = 3;
  localparam int HIGH_W = 5;

  // Instruction cycle timing: the least time rounds up to whole clocks
  localparam int CLK_PERIOD_NS = 5;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Memory-mapped control register locations, mirrored in every bank
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PC_LOW = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_POINTER = 7'h04;
  localparam logic [6:0] ADDR_PC_HIGH = 7'h0A;

  // Status register fields and reset value
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_RP0 = 5;
  localparam int ST_RP1 = 6;
  localparam int ST_IRP = 7;
  localparam logic [7:0] STATUS_RESET = 8'h18;

  // Instruction groups in bits 13:12
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;

  // Fixed words
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [13:0] RETURN_WORD = 14'h0008;
  localparam logic [13:0] RET_INT_WORD = 14'h0009;

  // ALU operations
  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0, ALU_PASS_B = 4'h1, ALU_ADD = 4'h2, ALU_SUB = 4'h3,
    ALU_AND = 4'h4, ALU_IOR = 4'h5, ALU_XOR = 4'h6, ALU_COM = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_RL = 4'hA, ALU_RR = 4'hB,
    ALU_SWAP = 4'hC, ALU_CLR = 4'hD, ALU_BCLR = 4'hE, ALU_BSET = 4'hF
  } alu_op_type;

endpackage

// ===== logic/alu8.sv
`timescale 1ns/1ps
module alu8 (
  // Operation select
  input wire core_pkg::alu_op_type op,
  input wire logic [2:0] bit_sel,
  input wire logic carry_in,
  // Operands
  input wire logic [core_pkg::DATA_W-1:0] a,
  input wire logic [core_pkg::DATA_W-1:0] b,
  // Result and flags
  output logic [core_pkg::DATA_W-1:0] y,
  output logic c_out,
  output logic nibble_overflow_out,
  output logic z_out,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z
);
  import core_pkg::*;

  logic [DATA_W:0] wide;
  logic [4:0] low;

  // Subtraction is b plus the inverse of a plus one, so carry means no borrow
  always_comb begin
    y = a;
    wide = '0;
    low = '0;
    c_out = carry_in;
    nibble_overflow_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b1;
    unique case (op)
      ALU_PASS_A: upd_z = 1'b0;
      ALU_PASS_B: y = b;
      ALU_ADD: begin
        wide = {1'b0, b} + {1'b0, a}; // see (RQ8) (RQ9)
        low = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        y = wide[DATA_W-1:0];
        c_out = wide[DATA_W];
        nibble_overflow_out = low[4];
        upd_c = 1'b1; // see (RQ13)
        upd_dc = 1'b1;
      end
      ALU_SUB: begin
        wide = {1'b0, b} + {1'b0, ~a} + 9'h001; // see (RQ9)
        low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        y = wide[DATA_W-1:0];
        c_out = wide[DATA_W]; // see (RQ14)
        nibble_overflow_out = low[4]; // see (RQ14)
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      ALU_AND: y = a & b;
      ALU_IOR: y = a | b;
      ALU_XOR: y = a ^ b;
      ALU_COM: y = ~b;
      ALU_INC: y = b + 8'h01;
      ALU_DEC: y = b - 8'h01;
      ALU_RL: begin
        y = {b[6:0], carry_in}; // see (RQ8)
        c_out = b[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      ALU_RR: begin
        y = {carry_in, b[7:1]};
        c_out = b[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      ALU_SWAP: begin
        y = {b[3:0], b[7:4]};
        upd_z = 1'b0;
      end
      ALU_CLR: y = 8'h00;
      ALU_BCLR: begin
        y = b & ~(8'h01 << bit_sel);
        upd_z = 1'b0;
      end
      ALU_BSET: begin
        y = b | (8'h01 << bit_sel);
        upd_z = 1'b0;
      end
    endcase
    z_out = (y == 8'h00); // see (RQ16)
  end

endmodule // alu8

// ===== logic/data_ram.sv
`timescale 1ns/1ps
module data_ram #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Registered read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data re-registered every clock, so it settles one clock after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // data_ram

// ===== logic/harvard_core.sv
`timescale 1ns/1ps
// Summary of operation
// (RQ1) Separate program and data buses, concurrent access
// (RQ2) Fourteen-bit instruction word fetched whole per cycle
// (RQ3) Fetch of next overlaps execute of current
// (RQ4) One instruction cycle each, except branches
// (RQ5) Control registers and PC live in data space
// (RQ6) Direct and pointer-indirect data addressing supported
// (RQ7) Every operation works on every register
// (RQ8) Eight-bit ALU: add, subtract, shift, logic
// (RQ9) Arithmetic is two's complement
// (RQ10) Two operands: accumulator plus register or literal
// (RQ11) One operand: accumulator or data register
// (RQ12) Accumulator is eight bits, not addressable
// (RQ13) ALU updates carry, nibble carry, zero flags
// (RQ14) Subtract: carry and nibble carry mean no-borrow
// (RQ15) Branches discard prefetched word, take two cycles
// (RQ16) Zero flag set exactly when result zero
module harvard_core #(
  parameter int INSTR_CYCLE_CLKS = core_pkg::INSTR_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Program memory fetch bus
  output logic [core_pkg::PC_W-1:0] prog_addr,
  input wire logic [core_pkg::INSTR_W-1:0] prog_data,
  // Core state visible to the system
  output logic [core_pkg::DATA_W-1:0] w_value,
  output logic [core_pkg::DATA_W-1:0] status_value,
  output logic [core_pkg::DATA_W-1:0] pointer_value,
  output logic retire
);
  import core_pkg::*;

  localparam int CNT_W = $clog2(INSTR_CYCLE_CLKS);

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state

  logic [CNT_W-1:0] phase_reg;
  logic exec_en;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [INSTR_W-1:0] ir_reg;
  logic flush_reg;
  logic flush_next;
  logic [DATA_W-1:0] w_reg;
  logic [DATA_W-1:0] status_reg;
  logic [DATA_W-1:0] status_next;
  logic [DATA_W-1:0] fsr_reg;
  logic [HIGH_W-1:0] pclath_reg;
  logic retire_reg;
  logic [STACK_AW-1:0] sp_reg;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the executing word

  logic [1:0] grp;
  logic [3:0] bop;
  logic dest_f;
  logic [6:0] f7;
  logic [7:0] k8;
  logic [2:0] bit_sel;
  alu_op_type alu_op;
  logic use_lit;
  logic wr_w;
  logic wr_f;
  logic skip_zero;
  logic bit_test;
  logic do_call;
  logic do_goto;
  logic do_ret;

  assign grp = ir_reg[13:12];
  assign bop = ir_reg[11:8];
  assign dest_f = ir_reg[7];
  assign f7 = ir_reg[6:0];
  assign k8 = ir_reg[7:0];
  assign bit_sel = ir_reg[9:7];

  // Any byte operation may target any file address, none is special-cased
  always_comb begin
    alu_op = ALU_PASS_A;
    use_lit = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    skip_zero = 1'b0;
    bit_test = 1'b0;
    do_call = 1'b0;
    do_goto = 1'b0;
    do_ret = 1'b0;
    unique case (grp)
      GRP_BYTE: begin
        if (bop == 4'h0) begin
          // Store accumulator, or a no-operand control word
          wr_f = dest_f;
          do_ret = (ir_reg == RETURN_WORD) || (ir_reg == RET_INT_WORD);
        end else begin
          wr_w = !dest_f; // see (RQ11)
          wr_f = dest_f; // see (RQ7)
          unique case (bop)
            4'h1: alu_op = ALU_CLR;
            4'h2: alu_op = ALU_SUB;
            4'h3: alu_op = ALU_DEC;
            4'h4: alu_op = ALU_IOR;
            4'h5: alu_op = ALU_AND;
            4'h6: alu_op = ALU_XOR;
            4'h7: alu_op = ALU_ADD;
            4'h8: alu_op = ALU_PASS_B;
            4'h9: alu_op = ALU_COM;
            4'hA: alu_op = ALU_INC;
            4'hB: begin
              alu_op = ALU_DEC;
              skip_zero = 1'b1;
            end
            4'hC: alu_op = ALU_RR;
            4'hD: alu_op = ALU_RL;
            4'hE: alu_op = ALU_SWAP;
            default: begin
              alu_op = ALU_INC;
              skip_zero = 1'b1;
            end
          endcase
        end
      end
      GRP_BIT: begin
        alu_op = bop[2] ? ALU_BSET : ALU_BCLR;
        wr_f = !bop[3];
        bit_test = bop[3];
      end
      GRP_JUMP: begin
        do_call = !ir_reg[11];
        do_goto = ir_reg[11];
      end
      GRP_LIT: begin
        use_lit = 1'b1; // see (RQ10)
        wr_w = 1'b1;
        casez (bop)
          4'b00??: alu_op = ALU_PASS_B;
          4'b01??: begin
            alu_op = ALU_PASS_B;
            do_ret = 1'b1;
          end
          4'b1000: alu_op = ALU_IOR;
          4'b1001: alu_op = ALU_AND;
          4'b1010: alu_op = ALU_XOR;
          4'b110?: alu_op = ALU_SUB;
          4'b111?: alu_op = ALU_ADD;
          default: wr_w = 1'b0;
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data address and operand fetch

  logic [RAM_AW-1:0] eff_addr;
  logic [6:0] reg_sel;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] fdata;
  logic [PC_W-1:0] pc_exec;
  logic is_ctrl;
  logic ram_we;

  // Location zero reaches through the pointer register, others are direct
  assign eff_addr = (f7 == ADDR_INDIRECT) ? {status_reg[ST_IRP], fsr_reg} :
                    {status_reg[ST_RP1:ST_RP0], f7}; // see (RQ6)
  assign reg_sel = eff_addr[6:0];
  assign pc_exec = PC_W'(pc_reg - 1'b1);
  assign is_ctrl = (reg_sel == ADDR_INDIRECT) || (reg_sel == ADDR_PC_LOW) ||
                   (reg_sel == ADDR_STATUS) || (reg_sel == ADDR_POINTER) ||
                   (reg_sel == ADDR_PC_HIGH);

  // Control registers answer in every bank; the accumulator has no address
  always_comb begin
    unique case (reg_sel)
      ADDR_INDIRECT: fdata = 8'h00;
      ADDR_PC_LOW: fdata = pc_exec[7:0]; // see (RQ5)
      ADDR_STATUS: fdata = status_reg;
      ADDR_POINTER: fdata = fsr_reg;
      ADDR_PC_HIGH: fdata = {3'h0, pclath_reg};
      default: fdata = ram_rdata; // see (RQ12)
    endcase
  end

  // Data access runs alongside the program fetch on its own port
  assign ram_we = exec_en && !flush_reg && wr_f && !is_ctrl; // see (RQ1)

  data_ram #(
    .AW(RAM_AW),
    .DW(DATA_W)
  ) u_ram (
    .clk(clk),
    .rst(rst),
    .we(ram_we),
    .waddr(eff_addr),
    .wdata(alu_y),
    .raddr(eff_addr),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ALU

  logic [DATA_W-1:0] alu_y;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic upd_c;
  logic upd_dc;
  logic upd_z;

  alu8 u_alu (
    .op(alu_op),
    .bit_sel(bit_sel),
    .carry_in(status_reg[ST_C]),
    .a(w_reg),
    .b(use_lit ? k8 : fdata), // see (RQ10)
    .y(alu_y),
    .c_out(alu_c),
    .nibble_overflow_out(alu_dc),
    .z_out(alu_z),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle divider

  // One execute enable per instruction cycle; data reads settle long before it
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= '0;
    end else if (exec_en) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  assign exec_en = (phase_reg == CNT_W'(INSTR_CYCLE_CLKS - 1)); // see (RQ4)

  ////////////////////////////////////////////////////////////////////////////
  // Program flow

  logic skip_cond;
  logic pcl_write;

  assign skip_cond = (skip_zero && alu_z) ||
                     (bit_test && (fdata[bit_sel] == ir_reg[10]));
  assign pcl_write = wr_f && (reg_sel == ADDR_PC_LOW);

  // Any change of flow voids the word already fetched
  always_comb begin
    pc_next = PC_W'(pc_reg + 1'b1);
    flush_next = 1'b0;
    if (!flush_reg) begin
      if (do_goto || do_call) begin
        pc_next = {pclath_reg[4:3], ir_reg[10:0]};
        flush_next = 1'b1; // see (RQ15)
      end else if (do_ret) begin
        pc_next = stack_mem[STACK_AW'(sp_reg - 1'b1)];
        flush_next = 1'b1; // see (RQ15)
      end else if (pcl_write) begin
        pc_next = {pclath_reg, alu_y};
        flush_next = 1'b1; // see (RQ15)
      end else if (skip_cond) begin
        flush_next = 1'b1;
      end
    end
  end

  // Fetch the next word while the current one executes
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_reg <= '0;
      ir_reg <= NOP_WORD;
      flush_reg <= 1'b1;
      retire_reg <= 1'b0;
    end else begin
      retire_reg <= exec_en && !flush_reg;
      if (exec_en) begin
        pc_reg <= pc_next; // see (RQ3)
        ir_reg <= prog_data; // see (RQ2)
        flush_reg <= flush_next;
      end
    end
  end

  // Return stack wraps silently when over- or under-run
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_reg <= '0;
    end else if (exec_en && !flush_reg) begin
      if (do_call) begin
        sp_reg <= sp_reg + 1'b1;
      end else if (do_ret) begin
        sp_reg <= sp_reg - 1'b1;
      end
    end
  end

  // Return address is the fetch address, one past the call
  always_ff @(posedge clk) begin
    if (exec_en && !flush_reg && do_call) begin
      stack_mem[sp_reg] <= pc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and control registers

  // Literal load on return also lands in the accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      w_reg <= '0;
    end else if (exec_en && !flush_reg && wr_w) begin
      w_reg <= alu_y; // see (RQ12)
    end
  end

  // Flag results override a direct write of the same bits
  always_comb begin
    status_next = status_reg;
    if (wr_f && (reg_sel == ADDR_STATUS)) begin
      status_next = {alu_y[7:5], status_reg[ST_TO:ST_PD], alu_y[2:0]};
    end
    if (upd_c) begin
      status_next[ST_C] = alu_c; // see (RQ13) (RQ14)
    end
    if (upd_dc) begin
      status_next[ST_DC] = alu_dc; // see (RQ13)
    end
    if (upd_z) begin
      status_next[ST_Z] = alu_z; // see (RQ16)
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= STATUS_RESET;
    end else if (exec_en && !flush_reg) begin
      status_reg <= status_next;
    end
  end

  // Pointer and high program counter bits as ordinary file targets
  always_ff @(posedge clk) begin
    if (rst) begin
      fsr_reg <= '0;
      pclath_reg <= '0;
    end else if (exec_en && !flush_reg && wr_f) begin
      if (reg_sel == ADDR_POINTER) begin
        fsr_reg <= alu_y; // see (RQ5)
      end
      if (reg_sel == ADDR_PC_HIGH) begin
        pclath_reg <= alu_y[HIGH_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prog_addr = pc_reg; // see (RQ1)
  assign w_value = w_reg;
  assign status_value = status_reg;
  assign pointer_value = fsr_reg;
  assign retire = retire_reg;

endmodule // harvard_core

// ===== sim/core_props.sv
`timescale 1ns/1ps
module core_props #(
  parameter int INSTR_CYCLE_CLKS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Program fetch bus
  input wire logic [core_pkg::PC_W-1:0] prog_addr,
  input wire logic [core_pkg::INSTR_W-1:0] prog_data,
  // Core state
  input wire logic [core_pkg::DATA_W-1:0] w_value,
  input wire logic [core_pkg::DATA_W-1:0] status_value,
  input wire logic [core_pkg::DATA_W-1:0] pointer_value,
  input wire logic retire
);
  import core_pkg::*;
  int gap_reg;
  int ret_reg;
  default clocking @(posedge clk); endclocking

  ////////////////////////////////////////////////////////////////
  // Cycles since the fetch address last moved and since last retire
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_reg <= 0;
      ret_reg <= 0;
    end else begin
      gap_reg <= $changed(prog_addr) ? 1 : gap_reg + 1;
      ret_reg <= retire ? 1 : ret_reg + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reset is checked without a disable, everything else is masked by it
  reset_state_a: assert property (rst |=> (prog_addr == '0 && w_value == '0
    && status_value == STATUS_RESET && pointer_value == '0 && !retire))
    else $error("state after reset wrong");
  retire_pulse_a: assert property (disable iff (rst) retire |=> !retire)
    else $error("retire longer than one cycle");
  retire_gap_a: assert property (disable iff (rst) retire |->
    (ret_reg == INSTR_CYCLE_CLKS || ret_reg == 2 * INSTR_CYCLE_CLKS))
    else $error("retire spacing wrong");
  addr_timing_a: assert property (disable iff (rst)
    ($changed(prog_addr) || gap_reg == INSTR_CYCLE_CLKS)
    |-> ($changed(prog_addr) && gap_reg == INSTR_CYCLE_CLKS))
    else $error("fetch address moved off the instruction cycle");
  retire_fetch_a: assert property (disable iff (rst) retire |-> $changed(prog_addr))
    else $error("retire without a fetch");
  w_quiet_a: assert property (disable iff (rst)
    $changed(w_value) |-> $changed(prog_addr))
    else $error("accumulator changed between instructions");
  regs_quiet_a: assert property (disable iff (rst)
    $changed({status_value, pointer_value}) |-> $changed(prog_addr))
    else $error("status or pointer changed between instructions");
  status_ones_a: assert property (disable iff (rst) status_value[4:3] == 2'b11)
    else $error("fixed status bits wrong");
endmodule // core_props

bind harvard_core core_props #(.INSTR_CYCLE_CLKS(INSTR_CYCLE_CLKS)) core_props_i (
  .clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
  .w_value(w_value), .status_value(status_value), .pointer_value(pointer_value),
  .retire(retire));

// ===== sim/prog_rom.sv
`timescale 1ns/1ps
module prog_rom (
  // Clock and mode
  input wire logic clk,
  input wire logic slow,
  // Fetch bus
  input wire logic [core_pkg::PC_W-1:0] prog_addr,
  output logic [core_pkg::INSTR_W-1:0] prog_data
);
  import core_pkg::*;
  logic [INSTR_W-1:0] mem [0:63];
  logic [PC_W-1:0] addr_reg;

  ////////////////////////////////////////////////////////////////
  // Own bus, one whole word per read; slow mode shows junk first
  always_ff @(posedge clk) begin
    addr_reg <= prog_addr;
    if (slow && prog_addr != addr_reg) begin
      prog_data <= ~prog_data;
    end else begin
      prog_data <= mem[prog_addr[5:0]];
    end
  end
endmodule // prog_rom

// ===== sim/tb_harvard_core.sv
`timescale 1ns/1ps
module tb_harvard_core;
  import core_pkg::*;
  localparam int N = 4;
  localparam int LEN = 48;
  logic clk, rst, slow, retire;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  logic [DATA_W-1:0] w_value, status_value, pointer_value;
  int n_mismatch = 0, checks = 0, seed = 79266, cycles = 0;
  int prog [0:LEN-1];
  int mw, mc, mdc, mz, mptr, mram, mpc;

  harvard_core #(.INSTR_CYCLE_CLKS(N)) harvard_core_i (.clk(clk), .rst(rst),
    .prog_addr(prog_addr), .prog_data(prog_data), .w_value(w_value),
    .status_value(status_value), .pointer_value(pointer_value), .retire(retire));
  prog_rom prog_rom_i (.clk(clk), .slow(slow), .prog_addr(prog_addr), .prog_data(prog_data));

  ////////////////////////////////////////////////////////////////
  // Clock, and a ceiling well above two program runs
  initial begin
    clk = 0;
    rst = 1;
    slow = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Model arithmetic: subtract is file or literal minus accumulator
  task automatic arith(input int a, input int b, input int sub);
    int r;
    r = sub ? a - b : a + b;
    mc = sub ? (a >= b) : (r > 255);
    mdc = sub ? ((a & 15) >= (b & 15)) : ((a & 15) + (b & 15) > 15);
    mw = r & 255;
    mz = (mw == 0);
  endtask

  // Random program; word 1 seeds the RAM cell so it is never read unknown
  task automatic load();
    int r, k, wd;
    for (int i = 0; i < LEN; i++) begin
      r = (i < 2) ? i * 6 : $unsigned($random(seed)) % 10;
      k = $random(seed) & 255;
      case (r)
        0: wd = 14'h3000 | k;
        1: wd = 14'h3800 | k;
        2: wd = 14'h3900 | k;
        3: wd = 14'h3A00 | k;
        4: wd = 14'h3C00 | k;
        5: wd = 14'h3E00 | k;
        6: wd = 14'h00A0;
        7: wd = (k & 1) ? 14'h0720 : 14'h0220;
        8: wd = (k & 1) ? 14'h0AA0 : 14'h0084;
        default: wd = (i < LEN - 3) ? 14'h2800 | (i + 2) : 14'h0000;
      endcase
      if (i == LEN - 1) wd = 14'h2800 | i;
      prog[i] = wd;
      prog_rom_i.mem[i] = wd;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Reset, then follow every retire with the model until the end loop
  task automatic run(input logic slow_mode);
    int gap, wd, op, jmp, nxt, prev_jmp, last;
    slow <= slow_mode;
    rst <= 1;
    load();
    repeat (8) @(posedge clk);
    rst <= 0;
    {mw, mc, mdc, mz, mptr, mpc, last} = '0;
    gap = -1;
    prev_jmp = 1;
    while (!last) begin
      @(posedge clk);
      gap++;
      if (retire === 1'b1) begin
        wd = prog[mpc];
        op = (wd >> 8) & 15;
        last = (mpc == LEN - 1);
        jmp = 0;
        nxt = mpc + 1;
        if ((wd >> 12) == 3) begin
          if (op < 4) mw = wd & 255;
          else if (op >= 12) arith(wd & 255, mw, op < 14);
          else begin
            mw = (op == 8) ? (mw | wd) & 255 : (op == 9) ? mw & wd : (mw ^ wd) & 255;
            mz = (mw == 0);
          end
        end else if ((wd >> 12) == 2) begin
          jmp = 1;
          nxt = wd & 2047;
        end else if (op == 0 && (wd & 128)) begin
          if ((wd & 127) == 4) mptr = mw;
          else mram = mw;
        end else if (op == 7 || op == 2) begin
          arith(mram, mw, op == 2);
        end else if (op == 10) begin
          mram = (mram + 1) & 255;
          mz = (mram == 0);
        end
        check(w_value === DATA_W'(mw), "accumulator");
        check(status_value === {3'b000, 2'b11, mz[0], mdc[0], mc[0]}, "flags");
        check(pointer_value === DATA_W'(mptr), "pointer");
        check(prog_addr === PC_W'(jmp ? nxt : mpc + 2), "fetch address");
        check(gap == (prev_jmp ? 2 * N : N), "cycle length");
        gap = 0;
        prev_jmp = jmp;
        mpc = nxt;
      end
    end
  endtask

  // Second run resets mid-loop with the slow memory
  initial begin
    run(1'b0);
    run(1'b1);
    results();
  end
endmodule // tb_harvard_core
